// *** rtl/dac_spi_pkg.sv ***
// Constants and carrier types for the serial command front end of the DAC.
// Shared by the front end, its pin synchroniser and its shift register.
package dac_spi_pkg;

  localparam int CLK_FREQ_HZ        = 50000000;
  localparam int SYNC_STAGES        = 2;
  // Frame geometry
  localparam int CMD_BITS           = 8;
  localparam int LONG_CMD_BITS      = 24;
  localparam int BIT_CNT_W          = 5;
  localparam logic [4:0] LAST_CMD_BIT  = 5'h07;
  localparam logic [4:0] LAST_LONG_BIT = 5'h17;
  // Command byte field positions
  localparam int ADDR_MSB           = 7;
  localparam int ADDR_LSB           = 3;
  localparam int OPC_MSB            = 2;
  localparam int OPC_LSB            = 1;
  localparam int RSVD_BIT           = 0;
  localparam logic [4:0] ADDR_RESET = 5'h00;
  // Opcode encodings
  localparam logic [1:0] OPC_WRITE   = 2'h0;
  localparam logic [1:0] OPC_READ    = 2'h3;
  localparam logic [1:0] OPC_ENABLE  = 2'h2;
  localparam logic [1:0] OPC_DISABLE = 2'h1;
  // Address map split: volatile locations run from zero to this value
  localparam logic [4:0] VOL_ADDR_MAX = 5'h0A;
  localparam logic [4:0] NV_ADDR_MIN  = 5'h10;
  localparam logic [4:0] NV_ADDR_MAX  = 5'h1A;

  typedef enum logic [1:0] {
    CMD_WRITE,
    CMD_READ,
    CMD_ENABLE,
    CMD_DISABLE
  } cmd_e;

  // Pin levels after synchronisation
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic mosi;
    logic hv;
  } pins_s;

  // One decoded command handed to the memory side
  typedef struct packed {
    cmd_e       cmd;
    logic [4:0] addr;
    logic [15:0] data;
  } cmd_s;

endpackage

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for the serial pins.
// Assumes every input is asynchronous to CLK.
`timescale 1ns/1ns
module pin_sync
  import dac_spi_pkg::*;
(
  // Clock and reset
  input  wire logic  CLK,
  input  wire logic  SRST,
  // Raw and synchronised pins
  input  wire pins_s pins_in,
  output pins_s      pins_out
);

  pins_s stage1_r;
  pins_s stage2_r;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      stage1_r <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0, hv: 1'b0};
      stage2_r <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0, hv: 1'b0};
    end else begin
      stage1_r <= pins_in;
      stage2_r <= stage1_r;
    end
  end

  assign pins_out = stage2_r;

endmodule

// *** rtl/bit_shifter.sv ***
// Serial-in shift register with a bit counter for one frame.
// Assumes strobes are single-cycle and already synchronous to CLK.
`timescale 1ns/1ns
module bit_shifter
  import dac_spi_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  SRST,
  // Control
  input  wire logic                  clear,
  input  wire logic                  shift,
  input  wire logic                  din,
  // State
  output logic [LONG_CMD_BITS-1:0]   sreg,
  output logic [BIT_CNT_W-1:0]       count
);

  logic [LONG_CMD_BITS-1:0] sreg_r;
  logic [BIT_CNT_W-1:0]     count_r;
  logic [BIT_CNT_W-1:0]     count_nxt;

  // Count wraps after a full long command so repeats restart at zero
  assign count_nxt = (count_r == LAST_LONG_BIT) ? '0
                   : count_r + BIT_CNT_W'(1);

  always_ff @(posedge CLK) begin
    if (SRST || clear) begin
      sreg_r  <= '0;
      count_r <= '0;
    end else if (shift) begin
      sreg_r  <= {sreg_r[LONG_CMD_BITS-2:0], din};
      count_r <= count_nxt;
    end
  end

  assign sreg  = sreg_r;
  assign count = count_r;

endmodule

// *** rtl/dac_spi_cmd.sv ***
// Serial command front end of the DAC: framing, command decode, status out.
// Assumes the serial pins are asynchronous and CLK is much faster than SCK.
//
// Summary of operation
// - Serial input is sampled on each rising clock edge.
// - Serial output changes on falling clock edges; an error forces it low at once.
// - Serial output is driven as soon as chip select goes active.
// - Chip select going active starts a frame and clears the bit counter.
// - Chip select inactive resets state and pointer; activity then ignored.
// - A command in error drives the error bit position low.
// - Power-on reset clears state machine and address pointer to zero.
// - Opcode 00 is write, 11 is read; both normal-mode commands.
// - Opcode 10 enables, 01 disables a configuration bit; high voltage only.
// - Reads and writes are 24 clocks; continuous forms repeat that length.
// - Normal logic level on the high-voltage pin means a normal command.
// - Command byte holds a 5-bit address, 2-bit opcode and reserved bit.
// - Ones go out for seven command bits, then the error flag.
// - Read or write under high voltage is ignored without an error.
// - Nonvolatile writes allow single access only, no repetition.
// - Valid commands may follow back to back under one chip select.
// - Error flag is one for a valid address/opcode pair, else zero.
// - Partial byte commands ignored; after error, all ignored, output low.
// - Clock modes 0,0 and 1,1 both sample rising and shift falling.
`timescale 1ns/1ns
module dac_spi_cmd
  import dac_spi_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Serial pins (asynchronous)
  input  wire logic        CS_N,
  input  wire logic        SCK,
  input  wire logic        SDI,
  input  wire logic        HIGH_VOLTAGE_CMD_PIN,
  output logic             SDO_O,
  output logic             SDO_OE,
  // Read data for the data bytes of a read
  input  wire logic [15:0] RD_DATA,
  // Decoded command towards the memory side
  output cmd_s             CMD,
  output logic             CMD_VALID,
  output logic             NV_WRITE_PENDING,
  output logic             COMMAND_ERROR_FLAG,
  output logic [4:0]       ADDR_PTR
);

  pins_s pins_raw;
  pins_s pins;
  logic  sck_d_r;
  logic  sel_n_d_r;
  logic  frame_start;
  logic  frame_end;
  logic  active;
  logic  sck_rise;
  logic  sck_fall;

  logic [LONG_CMD_BITS-1:0] sreg;
  logic [BIT_CNT_W-1:0]     count;
  logic                     shift_in;

  assign pins_raw = '{sel_n: CS_N, sck: SCK, mosi: SDI,
                      hv: HIGH_VOLTAGE_CMD_PIN};

  pin_sync u_sync (
    .CLK      (CLK),
    .SRST     (SRST),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sck_d_r   <= 1'b0;
      sel_n_d_r <= 1'b1;
    end else begin
      sck_d_r   <= pins.sck;
      sel_n_d_r <= pins.sel_n;
    end
  end

  assign active      = !pins.sel_n;
  assign frame_start = sel_n_d_r && !pins.sel_n;
  assign frame_end   = !sel_n_d_r && pins.sel_n;
  // Edges of either idle level count alike, so both modes work
  assign sck_rise    = active && !frame_start && pins.sck && !sck_d_r;
  assign sck_fall    = active && !frame_start && !pins.sck && sck_d_r;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA,
    ST_ERROR
  } state_e;

  state_e     state_r;
  state_e     state_nxt;
  logic [4:0] addr_r;
  logic [1:0] opc_r;
  logic       hv_r;
  logic       err_r;
  logic       nv_pend_r;
  logic       sdo_r;
  logic       cmd_valid_r;
  cmd_s       cmd_r;

  // Byte complete on the rising edge that takes its eighth bit
  logic       byte_done;
  logic       long_done;
  logic [7:0] cmd_byte;
  logic [4:0] rx_addr;
  logic [1:0] rx_opc;
  logic       rx_hv;
  logic       addr_vol;
  logic       addr_nv;
  logic       addr_ok;
  logic       is_long;
  logic       is_short;
  logic       combo_ok;
  logic       repeat_nv;
  logic       ignore_cmd;
  logic       in_cmd_byte;

  assign shift_in    = sck_rise && (state_r != ST_ERROR);
  assign byte_done   = shift_in && (count[2:0] == LAST_CMD_BIT[2:0]);
  assign long_done   = shift_in && (count == LAST_LONG_BIT);
  assign cmd_byte    = {sreg[CMD_BITS-2:0], pins.mosi};
  assign rx_addr     = cmd_byte[ADDR_MSB:ADDR_LSB];
  assign rx_opc      = cmd_byte[OPC_MSB:OPC_LSB];
  assign rx_hv       = pins.hv;
  assign addr_vol    = rx_addr <= VOL_ADDR_MAX;
  assign addr_nv     = rx_addr >= NV_ADDR_MIN && rx_addr <= NV_ADDR_MAX;
  assign addr_ok     = addr_vol || addr_nv;
  assign is_long     = rx_opc == OPC_WRITE || rx_opc == OPC_READ;
  assign is_short    = rx_opc == OPC_ENABLE || rx_opc == OPC_DISABLE;
  // Configuration bits live in the nonvolatile range only
  assign combo_ok    = addr_ok && (is_long || (is_short && addr_nv));
  // A command after a nonvolatile write in the same frame is an error
  assign repeat_nv   = nv_pend_r;
  assign ignore_cmd  = (is_long && rx_hv) || (is_short && !rx_hv);
  assign in_cmd_byte = state_r == ST_CMD;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (frame_start) begin
          state_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (byte_done) begin
          if (!combo_ok || repeat_nv) begin
            state_nxt = ST_ERROR;
          end else if (is_long) begin
            state_nxt = ST_DATA;
          end else begin
            state_nxt = ST_CMD;
          end
        end
      end
      ST_DATA: begin
        if (long_done) begin
          state_nxt = ST_CMD;
        end
      end
      ST_ERROR: begin
        state_nxt = ST_ERROR;
      end
    endcase
    if (!active) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r     <= ST_IDLE;
      addr_r      <= ADDR_RESET;
      opc_r       <= OPC_WRITE;
      hv_r        <= 1'b0;
      err_r       <= 1'b0;
      nv_pend_r   <= 1'b0;
      cmd_valid_r <= 1'b0;
      cmd_r       <= '{cmd: CMD_WRITE, addr: 5'h00, data: 16'h0000};
    end else begin
      state_r     <= state_nxt;
      cmd_valid_r <= 1'b0;
      if (!active) begin
        addr_r    <= ADDR_RESET;
        err_r     <= 1'b0;
        nv_pend_r <= 1'b0;
      end else if (in_cmd_byte && byte_done) begin
        addr_r <= rx_addr;
        opc_r  <= rx_opc;
        hv_r   <= rx_hv;
        err_r  <= !combo_ok || repeat_nv;
        if (combo_ok && !repeat_nv && is_short && !ignore_cmd) begin
          cmd_valid_r <= 1'b1;
          cmd_r <= '{cmd: (rx_opc == OPC_ENABLE) ? CMD_ENABLE : CMD_DISABLE,
                     addr: rx_addr, data: 16'h0000};
        end
      end else if (state_r == ST_DATA && long_done) begin
        // Full 24 clocks only; partial frames never reach here
        if (!(hv_r)) begin
          cmd_valid_r <= 1'b1;
          cmd_r <= '{cmd: (opc_r == OPC_READ) ? CMD_READ : CMD_WRITE,
                     addr: addr_r, data: {sreg[14:0], pins.mosi}};
          if (opc_r == OPC_WRITE && addr_r >= NV_ADDR_MIN) begin
            nv_pend_r <= 1'b1;
          end
        end
      end
    end
  end

  // Output bit chosen for the next falling edge
  logic       out_bit;
  logic [3:0] data_idx;
  logic       read_data;
  // Address and opcode are complete after seven bits; the eighth is reserved
  logic [4:0] pre_addr;
  logic [1:0] pre_opc;
  logic       pre_vol;
  logic       pre_nv;
  logic       pre_long;
  logic       pre_short;
  logic       pre_ok;

  assign pre_addr  = sreg[ADDR_MSB-1:ADDR_LSB-1];
  assign pre_opc   = sreg[OPC_MSB-1:OPC_LSB-1];
  assign pre_vol   = pre_addr <= VOL_ADDR_MAX;
  assign pre_nv    = pre_addr >= NV_ADDR_MIN && pre_addr <= NV_ADDR_MAX;
  assign pre_long  = pre_opc == OPC_WRITE || pre_opc == OPC_READ;
  assign pre_short = pre_opc == OPC_ENABLE || pre_opc == OPC_DISABLE;
  assign pre_ok    = (pre_vol || pre_nv) && !repeat_nv
                     && (pre_long || (pre_short && pre_nv));

  assign data_idx  = 4'(LAST_LONG_BIT - count);
  assign read_data = state_r == ST_DATA && opc_r == OPC_READ && !hv_r;
  // count already advanced past the rising edge that took the bit
  assign out_bit = (state_r == ST_ERROR) ? 1'b0
                 : (in_cmd_byte && count[2:0] == LAST_CMD_BIT[2:0])
                   ? pre_ok
                 : read_data ? RD_DATA[data_idx]
                 : 1'b1;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sdo_r <= 1'b1;
    end else if (frame_start) begin
      sdo_r <= 1'b1;
    end else if (sck_fall) begin
      sdo_r <= out_bit;
    end else if (state_r == ST_ERROR) begin
      sdo_r <= 1'b0;
    end else if (in_cmd_byte && byte_done && !(combo_ok && !repeat_nv)) begin
      sdo_r <= sdo_r;
    end
  end

  // Error state forces the line low at once, between falling edges too
  logic sdo_flag;
  assign sdo_flag = (state_r == ST_ERROR) ? 1'b0 : sdo_r;

  bit_shifter u_shift (
    .CLK   (CLK),
    .SRST  (SRST),
    .clear (frame_start || !active || (in_cmd_byte && byte_done && is_short)),
    .shift (shift_in),
    .din   (pins.mosi),
    .sreg  (sreg),
    .count (count)
  );

  assign SDO_O              = active ? sdo_flag : 1'b0;
  assign SDO_OE             = active;
  assign CMD                = cmd_r;
  assign CMD_VALID          = cmd_valid_r;
  assign NV_WRITE_PENDING   = nv_pend_r;
  assign COMMAND_ERROR_FLAG = !err_r;
  assign ADDR_PTR           = addr_r;

endmodule

// *** verification/dac_spi_cmd_assertions.sv ***
// Checker for the serial command front end, bound to its top ports.
// Assumes SCK half periods of at least 4 CLK and a steady HV pin.
`timescale 1ns/1ns
module dac_spi_cmd_assertions
  import dac_spi_pkg::*;
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       SRST,
  // Pins and outputs
  input wire logic       CS_N,
  input wire logic       SCK,
  input wire logic       HIGH_VOLTAGE_CMD_PIN,
  input wire logic       SDO_O,
  input wire logic       SDO_OE,
  input wire cmd_s       CMD,
  input wire logic       CMD_VALID,
  input wire logic       COMMAND_ERROR_FLAG,
  input wire logic [4:0] ADDR_PTR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_oe_on; $fell(CS_N) |-> ##[1:5] SDO_OE; endproperty
  a_oe_on: assert property (p_oe_on) else $error("sdo not driven");
  property p_oe_off; CS_N [*5] |-> !SDO_OE; endproperty
  a_oe_off: assert property (p_oe_off) else $error("sdo driven");
  property p_idle;
    CS_N [*5] |-> ADDR_PTR == ADDR_RESET && COMMAND_ERROR_FLAG;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_rst;
    $fell(SRST) |-> ADDR_PTR == ADDR_RESET && COMMAND_ERROR_FLAG;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_err_hold;
    !COMMAND_ERROR_FLAG && !CS_N |=> !COMMAND_ERROR_FLAG;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error lost");
  property p_err_low;
    !COMMAND_ERROR_FLAG && $past(!COMMAND_ERROR_FLAG) && SDO_OE |-> !SDO_O;
  endproperty
  a_err_low: assert property (p_err_low) else $error("sdo high");
  property p_no_exec; !COMMAND_ERROR_FLAG |-> !CMD_VALID; endproperty
  a_no_exec: assert property (p_no_exec) else $error("ran in error");
  property p_rise; CMD_VALID |-> $past(SCK, 2); endproperty
  a_rise: assert property (p_rise) else $error("not at rise");
  property p_fall;
    SDO_OE && $past(SDO_OE) && COMMAND_ERROR_FLAG && $changed(SDO_O)
      |-> !$past(SCK, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("not at fall");
  property p_mode;
    CMD_VALID |-> HIGH_VOLTAGE_CMD_PIN ==
      (CMD.cmd inside {CMD_ENABLE, CMD_DISABLE});
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
endmodule

// *** verification/spi_host_model.sv ***
// Behavioural SPI host that frames commands towards the front end.
// Assumes a free-running CLK of 20 ns; SCK is made from it at 160 ns.
`timescale 1ns/1ns
module spi_host_model (
  // System clock
  input  wire logic CLK,
  // Serial pins
  output logic      CS_N,
  output logic      SCK,
  output logic      SDI,
  input  wire logic SDO_O
);
  initial begin
    CS_N = 1'b1;
    SCK = 1'b0;
    SDI = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge CLK);
  endtask
  // Sends n bits MSB first; records SDO at every rising SCK edge
  task automatic xfer(input logic mode, input logic [47:0] b, input int n,
                      output logic [47:0] seen);
    seen = '0;
    SCK = mode;
    half();
    CS_N = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      SCK = 1'b0;
      SDI = b[47-i];
      half();
      SCK = 1'b1;
      seen[47-i] = SDO_O;
      half();
    end
    SCK = mode;
    half();
    CS_N = 1'b1;
    SDI = ~SDI;
  endtask
  // Traffic for another slave while this one is deselected
  task automatic noise();
    repeat (16) begin
      SCK = ~SCK;
      SDI = ~SDI;
      half();
    end
  endtask
endmodule

// *** verification/dac_spi_cmd_tb_top.sv ***
// Self-checking bench for the serial command front end.
// Assumes the host model drives the pins; the checker is bound at the foot.
`timescale 1ns/1ns
module dac_spi_cmd_tb_top
  import dac_spi_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hv = 1'b0;
  logic        cs_n, sck, sdi, sdo, sdo_oe, cmd_valid, flag;
  logic [15:0] rd_data = 16'hA5C3;
  logic [4:0]  ptr;
  logic [47:0] seen;
  cmd_s        cmd, last;
  int          errors = 0;
  int          tests_run = 0;
  int          pulses = 0;

  always #10 clk = ~clk;
  always @(posedge clk) if (cmd_valid) begin
    pulses <= pulses + 1;
    last <= cmd;
  end

  dac_spi_cmd uut (
    .CLK(clk), .SRST(srst), .CS_N(cs_n), .SCK(sck), .SDI(sdi),
    .HIGH_VOLTAGE_CMD_PIN(hv), .SDO_O(sdo), .SDO_OE(sdo_oe),
    .RD_DATA(rd_data), .CMD(cmd), .CMD_VALID(cmd_valid),
    .NV_WRITE_PENDING(), .COMMAND_ERROR_FLAG(flag), .ADDR_PTR(ptr));
  spi_host_model host (
    .CLK(clk), .CS_N(cs_n), .SCK(sck), .SDI(sdi), .SDO_O(sdo));

  task automatic chk(string what, logic [47:0] got, logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] cb(logic [4:0] a, logic [1:0] o);
    return {a, o, 1'b0};
  endfunction
  // One frame; checks executed commands and the error flag at its end
  task automatic run(logic mode, logic [47:0] b, int n, int np, logic fl);
    int p0;
    p0 = pulses;
    host.xfer(mode, b, n, seen);
    chk("pulses", 48'(pulses - p0), 48'(np));
    chk("flag", {47'h0, flag}, {47'h0, fl});
    repeat (10) @(negedge clk);
  endtask

  task automatic t_write();
    run(1'b0, {cb(5'h03, OPC_WRITE), 16'h5AC3, 24'h0}, 24, 1, 1'b1);
    chk("sdo", seen, 48'hFFFFFF_000000);
    chk("cmd", 48'(last), 48'({CMD_WRITE, 5'h03, 16'h5AC3}));
  endtask
  task automatic t_read();
    run(1'b1, {cb(5'h0A, OPC_READ), 40'h0}, 24, 1, 1'b1);
    chk("sdo", 48'(seen[47:40]), 48'hFF);
    chk("rd data", 48'(seen[39:24]), 48'(rd_data));
    chk("rd", 48'({last.cmd, last.addr}), 48'({CMD_READ, 5'h0A}));
  endtask
  task automatic t_b2b();
    run(1'b0, {cb(5'h01, OPC_WRITE), 16'h1234,
               cb(5'h0A, OPC_WRITE), 16'hFEDC}, 48, 2, 1'b1);
    chk("cmd", 48'(last), 48'({CMD_WRITE, 5'h0A, 16'hFEDC}));
  endtask
  task automatic t_err();
    run(1'b0, {cb(5'h0C, OPC_WRITE), 40'h0}, 24, 0, 1'b0);
    chk("sdo", seen, 48'hFE0000_000000);
    chk("flag", {47'h0, flag}, 48'h1);
    chk("ptr", 48'(ptr), 48'(ADDR_RESET));
  endtask
  task automatic t_hv();
    hv = 1'b1;
    run(1'b0, {cb(5'h03, OPC_WRITE), 40'h0}, 24, 0, 1'b1);
    run(1'b0, {cb(5'h10, OPC_ENABLE), 40'h0}, 8, 1, 1'b1);
    chk("en", 48'(last.cmd), 48'(CMD_ENABLE));
    run(1'b0, {cb(5'h11, OPC_DISABLE), 40'h0}, 8, 1, 1'b1);
    chk("dis", 48'(last.cmd), 48'(CMD_DISABLE));
    hv = 1'b0;
    run(1'b0, {cb(5'h10, OPC_ENABLE), 40'h0}, 8, 0, 1'b1);
  endtask
  task automatic t_abort();
    int p1;
    run(1'b0, {cb(5'h02, OPC_WRITE), 40'h0}, 20, 0, 1'b1);
    run(1'b0, {cb(5'h10, OPC_WRITE), 16'h0001,
               cb(5'h01, OPC_WRITE), 16'h0002}, 48, 1, 1'b0);
    p1 = pulses;
    host.noise();
    repeat (4) @(negedge clk);
    chk("pulses", 48'(pulses - p1), 48'h0);
    chk("oe", {47'h0, sdo_oe}, 48'h0);
  endtask
  task automatic t_reset();
    fork
      host.xfer(1'b0, {cb(5'h03, OPC_WRITE), 40'h0}, 24, seen);
      begin
        repeat (60) @(negedge clk);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
      end
    join
    repeat (10) @(negedge clk);
    chk("ptr", 48'(ptr), 48'(ADDR_RESET));
    chk("flag", {47'h0, flag}, 48'h1);
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    t_write();
    t_read();
    t_b2b();
    t_err();
    t_hv();
    t_abort();
    t_reset();
    summarize();
  end
endmodule

bind dac_spi_cmd dac_spi_cmd_assertions chk_i (
  .CLK(CLK), .SRST(SRST), .CS_N(CS_N), .SCK(SCK),
  .HIGH_VOLTAGE_CMD_PIN(HIGH_VOLTAGE_CMD_PIN), .SDO_O(SDO_O),
  .SDO_OE(SDO_OE), .CMD(CMD), .CMD_VALID(CMD_VALID),
  .COMMAND_ERROR_FLAG(COMMAND_ERROR_FLAG), .ADDR_PTR(ADDR_PTR));
